// >>> logic/enb_pkg.sv
// Package for the expanded non-multiplexed bus port: constants and types
package enb_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int LINES_W = 8;
   localparam logic [15:0] WIN_BASE = 16'h0100;
   localparam logic [15:0] WIN_LAST = 16'h01ff;
   localparam logic [7:0] DDR_RESET = 8'h00;
   localparam logic [1:0] CLK_SRC_INT_OUT = 2'h2;
   localparam int E_DIV = 4;
   localparam int RATE_DIV0 = 16;
   localparam int RATE_DIV1 = 128;
   localparam int RATE_DIV2 = 1024;
   localparam int RATE_DIV3 = 4096;
   localparam int RATE_W = 13;
   localparam int E_CNT_W = 2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b100
   } enb_state_t;
endpackage

// >>> logic/enb_rate_clk.sv
// Serial bit-rate clock generator with optional pin output
`timescale 1ns/1ps
module enb_rate_clk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic [1:0] speed,
   input wire logic [1:0] source,
   // Outputs
   output logic rate_clk,
   output logic pin_out,
   output logic pin_oe_n
);
   import enb_pkg::*;
   logic [RATE_W-1:0] cnt_q;
   logic [RATE_W-1:0] half_w;
   logic rate_q;
   logic out_q;
   logic oe_n_q;
   assign half_w = (speed == 2'h0) ? RATE_W'(RATE_DIV0 / 2) :
                   (speed == 2'h1) ? RATE_W'(RATE_DIV1 / 2) :
                   (speed == 2'h2) ? RATE_W'(RATE_DIV2 / 2) : RATE_W'(RATE_DIV3 / 2);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         rate_q <= 1'b0;
      end else if (cnt_q >= half_w - RATE_W'(1)) begin
         cnt_q <= '0;
         rate_q <= ~rate_q;
      end else begin
         cnt_q <= cnt_q + RATE_W'(1);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         out_q <= rate_q;
         oe_n_q <= (source != CLK_SRC_INT_OUT);
      end
   end
   assign rate_clk = rate_q;
   assign pin_out = out_q;
   assign pin_oe_n = oe_n_q;

   a_pin_follows: assert property (@(posedge clk) disable iff (rst)
      !oe_n_q |-> out_q == $past(rate_q))
      else $error("rate pin does not follow rate clock");
   a_pin_enable: assert property (@(posedge clk) disable iff (rst)
      $past(source) == CLK_SRC_INT_OUT |-> !oe_n_q)
      else $error("rate pin not enabled for source 10");
endmodule // enb_rate_clk

// >>> logic/enb_addr_port.sv
// Address port: per-line direction control, address drive and input reads
`timescale 1ns/1ps
module enb_addr_port #(
   parameter int LINES = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Direction control
   input wire logic [LINES-1:0] ddr_wdata,
   input wire logic ddr_we,
   output logic [LINES-1:0] ddr,
   // Address source and pins
   input wire logic [LINES-1:0] addr,
   input wire logic addr_load,
   input wire logic [LINES-1:0] pin_in,
   output logic [LINES-1:0] pin_out,
   output logic [LINES-1:0] pin_oe_n,
   output logic [LINES-1:0] in_data
);
   import enb_pkg::*;
   logic [LINES-1:0] ddr_q;
   logic [LINES-1:0] addr_q;
   logic [LINES-1:0] in_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ddr_q <= LINES'(DDR_RESET);
      end else if (ddr_we) begin
         ddr_q <= ddr_wdata;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= '0;
         in_q <= '0;
      end else begin
         if (addr_load) begin
            addr_q <= addr;
         end
         in_q <= pin_in;
      end
   end
   // Bit i of the direction register controls address line i
   genvar i;
   generate
      for (i = 0; i < LINES; i++) begin : g_line
         assign pin_out[i] = addr_q[i];
         assign pin_oe_n[i] = ~ddr_q[i];
         assign in_data[i] = ddr_q[i] ? addr_q[i] : in_q[i];
      end
   endgenerate
   assign ddr = ddr_q;

   a_ddr_reset: assert property (@(posedge clk) $fell(rst) |-> ddr_q == '0)
      else $error("direction register not cleared by reset");
   a_input_lines: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> (in_data & ~ddr_q) == ($past(pin_in) & ~ddr_q))
      else $error("input line does not read pin");
endmodule // enb_addr_port

// >>> logic/enb_bus_port.sv
// Expanded non-multiplexed external bus port: strobe, select, data routing
`timescale 1ns/1ps
// What this block does
// - Presents 8-bit data port, address lines, strobe, read/write and window select.
// - All external transfers are timed by the enable strobe.
// - Window select low exactly for addresses 0x0100 to 0x01ff, internal or not.
// - Address and select valid in strobe low phase, held through high phase.
// - Data port valid during strobe high phase, whoever drives it.
// - Read/write high for a read, low for a write.
// - Reset clears address direction register; bit i drives address line i.
// - Window reachable only once required address lines are outputs.
// - Lines left as inputs keep working as parallel inputs.
// - Reads of non-internal addresses sample the external data port.
// - Non-internal reads outside window also sample, with select inactive.
// - Internal accesses ignore whatever the external data port carries.
// - Clock source field 10 drives bit-rate clock on port two line two.
module enb_bus_port #(
   parameter int LINES = 8,
   parameter logic [7:0] NEED_LINES = 8'hff
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Processor access request
   input wire logic REQ,
   input wire logic [enb_pkg::ADDR_W-1:0] ADDR,
   input wire logic WRITE,
   input wire logic INTERNAL,
   input wire logic [enb_pkg::DATA_W-1:0] WDATA,
   output logic READY,
   output logic [enb_pkg::DATA_W-1:0] RDATA,
   output logic EXT_READ,
   output logic FAULT,
   // Internal data source for internal addresses
   input wire logic [enb_pkg::DATA_W-1:0] INT_RDATA,
   // Address line direction control
   input wire logic [LINES-1:0] DDR_WDATA,
   input wire logic DDR_WE,
   output logic [LINES-1:0] PORT_IN_DATA,
   // Serial clock control
   input wire logic [1:0] SERIAL_SPEED_FIELD,
   input wire logic [1:0] SERIAL_CLOCK_SOURCE_FIELD,
   output logic PORT_TWO_LINE_TWO_O,
   output logic PORT_TWO_LINE_TWO_OE_N,
   // External bus pins
   output logic ENABLE_STROBE,
   output logic READ_WRITE,
   output logic WINDOW_SELECT_N,
   input wire logic [LINES-1:0] ADDR_LINE_I,
   output logic [LINES-1:0] ADDR_LINE_O,
   output logic [LINES-1:0] ADDR_LINE_OE_N,
   input wire logic [enb_pkg::DATA_W-1:0] DATA_I,
   output logic [enb_pkg::DATA_W-1:0] DATA_O,
   output logic [enb_pkg::DATA_W-1:0] DATA_OE_N
);
   import enb_pkg::*;

   enb_state_t state_q, state_d;
   logic [E_CNT_W-1:0] cnt_q;
   logic [ADDR_W-1:0] addr_q;
   logic write_q;
   logic internal_q;
   logic [DATA_W-1:0] wdata_q;
   logic e_q;
   logic rw_q;
   logic sel_n_q;
   logic drive_q;
   logic ready_q;
   logic ext_q;
   logic fault_q;
   logic [DATA_W-1:0] rdata_q;
   logic [LINES-1:0] ddr_w;

   wire in_window = (ADDR >= WIN_BASE) && (ADDR <= WIN_LAST);
   wire window_blocked = in_window && ((ddr_w & NEED_LINES[LINES-1:0]) != NEED_LINES[LINES-1:0]);
   wire phase_end = (cnt_q == E_CNT_W'(E_DIV / 2 - 1));
   wire take = (state_q == ST_IDLE) && REQ;
   wire low_end = (state_q == ST_LOW) && phase_end;
   wire high_end = (state_q == ST_HIGH) && phase_end;
   wire win_q = (addr_q >= WIN_BASE) && (addr_q <= WIN_LAST);
   wire ext_cycle = !internal_q;
   wire [DATA_W-1:0] read_mux = ext_cycle ? DATA_I : INT_RDATA;

   enb_addr_port #(.LINES(LINES)) u_addr (
      .clk(MCLK),
      .rst(RST),
      .ddr_wdata(DDR_WDATA),
      .ddr_we(DDR_WE),
      .ddr(ddr_w),
      .addr(ADDR[LINES-1:0]),
      .addr_load(take && !window_blocked),
      .pin_in(ADDR_LINE_I),
      .pin_out(ADDR_LINE_O),
      .pin_oe_n(ADDR_LINE_OE_N),
      .in_data(PORT_IN_DATA)
   );

   enb_rate_clk u_rate (
      .clk(MCLK),
      .rst(RST),
      .speed(SERIAL_SPEED_FIELD),
      .source(SERIAL_CLOCK_SOURCE_FIELD),
      .rate_clk(),
      .pin_out(PORT_TWO_LINE_TWO_O),
      .pin_oe_n(PORT_TWO_LINE_TWO_OE_N)
   );

   // Each bus cycle is one strobe period: low phase then high phase
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (REQ && !window_blocked) state_d = ST_LOW;
         ST_LOW: if (phase_end) state_d = ST_HIGH;
         ST_HIGH: if (phase_end) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_q == ST_IDLE || phase_end) ? '0 : cnt_q + E_CNT_W'(1);
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         addr_q <= '0;
         write_q <= 1'b0;
         internal_q <= 1'b1;
         wdata_q <= '0;
      end else if (take && !window_blocked) begin
         addr_q <= ADDR;
         write_q <= WRITE;
         internal_q <= INTERNAL;
         wdata_q <= WDATA;
      end
   end

   // Pin timing: select and direction set at cycle start, held to its end
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         e_q <= 1'b0;
         rw_q <= 1'b1;
         sel_n_q <= 1'b1;
         drive_q <= 1'b0;
      end else begin
         e_q <= low_end || ((state_q == ST_HIGH) && !phase_end);
         if (take && !window_blocked) begin
            rw_q <= !WRITE;
            sel_n_q <= !in_window;
         end else if (high_end) begin
            rw_q <= 1'b1;
            sel_n_q <= 1'b1;
         end
         drive_q <= (low_end || ((state_q == ST_HIGH) && !phase_end)) && write_q;
      end
   end

   // Read data sampled at the close of the high phase
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rdata_q <= '0;
         ready_q <= 1'b0;
         ext_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         ready_q <= high_end || (take && window_blocked);
         fault_q <= take && window_blocked;
         ext_q <= high_end && !write_q && ext_cycle;
         if (high_end && !write_q) begin
            rdata_q <= read_mux;
         end
      end
   end

   assign READY = ready_q;
   assign RDATA = rdata_q;
   assign EXT_READ = ext_q;
   assign FAULT = fault_q;
   assign ENABLE_STROBE = e_q;
   assign READ_WRITE = rw_q;
   assign WINDOW_SELECT_N = sel_n_q;
   assign DATA_O = wdata_q;
   assign DATA_OE_N = {DATA_W{~drive_q}};

   a_sel_decode: assert property (@(posedge MCLK) disable iff (RST)
      $rose(e_q) |-> sel_n_q == !win_q)
      else $error("window select wrong for address");
   a_sel_stable_high: assert property (@(posedge MCLK) disable iff (RST)
      e_q && $past(e_q) |-> $stable(sel_n_q) && $stable(ADDR_LINE_O))
      else $error("address or select moved during high phase");
   a_rw_level: assert property (@(posedge MCLK) disable iff (RST)
      e_q |-> rw_q == !write_q)
      else $error("read/write level wrong");
   a_drive_write: assert property (@(posedge MCLK) disable iff (RST)
      !DATA_OE_N[0] |-> e_q && !rw_q)
      else $error("data driven outside write high phase");
   a_blocked_window: assert property (@(posedge MCLK) disable iff (RST)
      take && window_blocked |=> FAULT && READY && state_q == ST_IDLE)
      else $error("blocked window access not refused");
   a_outside_read: assert property (@(posedge MCLK) disable iff (RST)
      EXT_READ && !win_q |-> $past(sel_n_q))
      else $error("select active on outside read");
   a_ext_sample: assert property (@(posedge MCLK) disable iff (RST)
      high_end && !write_q && !internal_q |=> RDATA == $past(DATA_I))
      else $error("external read not sampled from data port");
   a_int_ignore: assert property (@(posedge MCLK) disable iff (RST)
      high_end && !write_q && internal_q |=> RDATA == $past(INT_RDATA))
      else $error("internal read took external data");
   a_cycle_len: assert property (@(posedge MCLK) disable iff (RST)
      take && !window_blocked |-> ##5 READY)
      else $error("bus cycle length wrong");

   // Checking aid: strobe-high clocks counted within one bus cycle
   localparam int HI_W = E_CNT_W + 1;
   logic [HI_W-1:0] hi_run_q;
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         hi_run_q <= '0;
      end else if (e_q) begin
         hi_run_q <= hi_run_q + HI_W'(1);
      end else begin
         hi_run_q <= '0;
      end
   end

   // Strobe and address timing
   a_strobe_high_max: assert property (@(posedge MCLK) disable iff (RST)
      hi_run_q <= HI_W'(E_DIV / 2))
      else $error("strobe high phase too long");
   a_strobe_full: assert property (@(posedge MCLK) disable iff (RST)
      $fell(e_q) |-> hi_run_q == HI_W'(E_DIV / 2))
      else $error("strobe high phase too short");
   a_strobe_low_first: assert property (@(posedge MCLK) disable iff (RST)
      $rose(e_q) |-> $past(state_q) == ST_LOW)
      else $error("strobe rose without low phase");
   a_idle_quiet: assert property (@(posedge MCLK) disable iff (RST)
      state_q == ST_IDLE |-> !e_q && rw_q && sel_n_q)
      else $error("bus pins active while idle");
   a_addr_held: assert property (@(posedge MCLK) disable iff (RST)
      state_q != ST_IDLE && $past(state_q) != ST_IDLE |-> $stable(addr_q) && $stable(sel_n_q)
      && $stable(rw_q))
      else $error("address or select moved within bus cycle");
   a_lines_drive: assert property (@(posedge MCLK) disable iff (RST)
      e_q |-> ADDR_LINE_O == addr_q[LINES-1:0])
      else $error("address lines differ from cycle address");
   a_sel_at_start: assert property (@(posedge MCLK) disable iff (RST)
      take && !window_blocked |=> sel_n_q == $past(!in_window))
      else $error("select not set at cycle start");
   a_rw_at_start: assert property (@(posedge MCLK) disable iff (RST)
      take && !window_blocked |=> rw_q == $past(!WRITE))
      else $error("read/write not set at cycle start");
   a_ext_window: assert property (@(posedge MCLK) disable iff (RST)
      EXT_READ && win_q |-> $past(!sel_n_q))
      else $error("select inactive on window read");
   a_read_level: assert property (@(posedge MCLK) disable iff (RST)
      EXT_READ |-> $past(rw_q))
      else $error("read/write low on a read");

   // Data port
   a_data_released: assert property (@(posedge MCLK) disable iff (RST)
      rw_q |-> DATA_OE_N == '1)
      else $error("data port driven during read");
   a_data_stable: assert property (@(posedge MCLK) disable iff (RST)
      !DATA_OE_N[0] && !$past(DATA_OE_N[0]) |-> $stable(DATA_O))
      else $error("write data moved while driven");
   a_write_drive: assert property (@(posedge MCLK) disable iff (RST)
      e_q && !rw_q |-> DATA_OE_N == '0)
      else $error("write data not driven in high phase");
   a_rdata_hold: assert property (@(posedge MCLK) disable iff (RST)
      !$past(high_end && !write_q) |-> $stable(RDATA))
      else $error("read data moved without a read");

   // Handshake outputs
   a_fault_ready: assert property (@(posedge MCLK) disable iff (RST)
      FAULT |-> READY && !EXT_READ)
      else $error("fault without ready");
   a_fault_idle: assert property (@(posedge MCLK) disable iff (RST)
      FAULT |-> state_q == ST_IDLE)
      else $error("refused access started a cycle");
   a_ext_ready: assert property (@(posedge MCLK) disable iff (RST)
      EXT_READ |-> READY && !internal_q)
      else $error("external read flag without external read");
   a_blocked_quiet: assert property (@(posedge MCLK) disable iff (RST)
      take && window_blocked |=> sel_n_q && !e_q && DATA_OE_N == '1)
      else $error("refused access moved bus pins");

   c_win_write: cover property (@(posedge MCLK) disable iff (RST) take && WRITE && in_window);
   c_win_read: cover property (@(posedge MCLK) disable iff (RST) EXT_READ && win_q);
   c_out_read: cover property (@(posedge MCLK) disable iff (RST) EXT_READ && !win_q);
   c_blocked: cover property (@(posedge MCLK) disable iff (RST) FAULT);
   c_int_read: cover property (@(posedge MCLK) disable iff (RST) READY && !EXT_READ && !FAULT);
endmodule // enb_bus_port

// >>> verif/enb_ext_mem.sv
// External glue model: RAM, serial adapter and read-only memory on the bus
`timescale 1ns/1ps
module enb_ext_mem (
   // Clock
   input wire logic mclk,
   // Bus from the device
   input wire logic e,
   input wire logic rw,
   input wire logic sel_n,
   input wire logic [7:0] a,
   input wire logic [7:0] d_in,
   // Data returned
   output logic [7:0] d_out
);
   logic [7:0] ram [128];
   logic [7:0] ada [2];
   logic [7:0] last_q = 8'h00;
   wire ram_en = e && !sel_n && !a[7];
   wire ada_en = e && !sel_n && a[7];
   // Read-only part lies outside the window, select acting as an address line
   wire rom_en = e && rw && sel_n;
   wire [7:0] rd = ram_en ? ram[a[6:0]] : (ada_en ? ada[a[0]] : (a ^ 8'h5a));
   wire drive = rw && (ram_en || ada_en || rom_en);
   // Released bus shows the inverse of the last value, not a stale copy
   assign d_out = drive ? rd : ~last_q;
   always @(posedge mclk) begin
      if (drive)
         last_q <= rd;
      if (!rw && ram_en)
         ram[a[6:0]] <= d_in;
      if (!rw && ada_en)
         ada[a[0]] <= d_in;
   end
endmodule // enb_ext_mem

// >>> verif/enb_bus_port_tb_top.sv
// Testbench for the expanded non-multiplexed bus port
`timescale 1ns/1ps
module enb_bus_port_tb_top;
   import enb_pkg::*;
   logic MCLK = 1'b0, RST = 1'b1, REQ = 1'b0, WRITE = 1'b0, INTERNAL = 1'b0, DDR_WE = 1'b0;
   logic [15:0] ADDR = 16'h0000;
   logic [7:0] WDATA = 8'h00, INT_RDATA = 8'h00, DDR_WDATA = 8'h00, pins = 8'h00;
   logic [1:0] spd = 2'h0, src = 2'h0;
   logic READY, EXT_READ, FAULT, es, rw, sel_n, p22, p22_oe_n, g_flt, g_ext;
   logic [7:0] RDATA, port_in, ao, aoe_n, dout, doe_n, part_d, g_rd;
   int failures = 0, n_compared = 0;
   wire [7:0] awire = (~aoe_n & ao) | (aoe_n & pins);
   wire [7:0] dwire = (~doe_n & dout) | (doe_n & part_d);
   enb_bus_port dut (.MCLK(MCLK), .RST(RST), .REQ(REQ), .ADDR(ADDR), .WRITE(WRITE),
      .INTERNAL(INTERNAL), .WDATA(WDATA), .READY(READY), .RDATA(RDATA), .EXT_READ(EXT_READ),
      .FAULT(FAULT), .INT_RDATA(INT_RDATA), .DDR_WDATA(DDR_WDATA), .DDR_WE(DDR_WE),
      .PORT_IN_DATA(port_in), .SERIAL_SPEED_FIELD(spd), .SERIAL_CLOCK_SOURCE_FIELD(src),
      .PORT_TWO_LINE_TWO_O(p22), .PORT_TWO_LINE_TWO_OE_N(p22_oe_n), .ENABLE_STROBE(es),
      .READ_WRITE(rw), .WINDOW_SELECT_N(sel_n), .ADDR_LINE_I(awire), .ADDR_LINE_O(ao),
      .ADDR_LINE_OE_N(aoe_n), .DATA_I(dwire), .DATA_O(dout), .DATA_OE_N(doe_n));
   enb_ext_mem partner (.mclk(MCLK), .e(es), .rw(rw), .sel_n(sel_n), .a(awire),
      .d_in(dwire), .d_out(part_d));
   always #2 MCLK = ~MCLK;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic set_ddr(input logic [7:0] v);
      @(posedge MCLK);
      #1 DDR_WDATA = v;
      DDR_WE = 1'b1;
      @(posedge MCLK);
      #1 DDR_WE = 1'b0;
   endtask
   // One access; lat is edges from raising the request to seeing READY
   task automatic acc(input logic [15:0] a, input logic w, input logic in,
      input logic [7:0] wd, input int lat);
      int n, hi;
      logic sel_lo, win;
      n = 0;
      hi = 0;
      sel_lo = 1'b0;
      win = a >= WIN_BASE && a <= WIN_LAST;
      @(posedge MCLK);
      #1 REQ = 1'b1;
      ADDR = a;
      WRITE = w;
      INTERNAL = in;
      WDATA = wd;
      do begin
         @(posedge MCLK);
         #1 n++;
         if (es === 1'b1 && !in) begin
            hi++;
            chk(doe_n, w ? 8'h00 : 8'hff, "data drive");
            if (w)
               chk(dout, wd, "write data");
            chk(ao & ~aoe_n, a[7:0] & ~aoe_n, "address lines");
            chk(rw, !w, "read write level");
            chk(sel_n, !win, "select level");
         end
         if (sel_n === 1'b0)
            sel_lo = 1'b1;
      end while (READY !== 1'b1 && n < 20);
      REQ = 1'b0;
      g_rd = RDATA;
      g_flt = FAULT;
      g_ext = EXT_READ;
      chk(g_flt, lat == 1, "refusal flag");
      if (!in) begin
         chk(16'(n), 16'(lat), "answer time");
         chk(16'(hi), lat == 1 ? 16'h0 : 16'(E_DIV / 2), "strobe high phase");
         chk(sel_lo, win && lat != 1, "select seen");
      end
   endtask
   task automatic t_reset();
      chk(aoe_n, 8'(~DDR_RESET), "lines input after reset");
      chk({es, rw, sel_n, p22_oe_n, doe_n}, {4'h7, 8'hff}, "idle pins");
   endtask
   task automatic t_blocked();
      acc(16'h0100, 1'b0, 1'b0, 8'h00, 1);
      set_ddr(8'h7f);
      acc(16'h01ff, 1'b1, 1'b0, 8'h11, 1);
   endtask
   task automatic t_port_in();
      set_ddr(8'h0f);
      pins = 8'ha5;
      repeat (2) @(posedge MCLK);
      #1 chk(aoe_n, 8'hf0, "line direction map");
      chk(port_in[7:4], 4'ha, "input lines");
      pins = 8'h5a;
      // Input levels held for at least two strobe periods
      repeat (2 * E_DIV) @(posedge MCLK);
      #1 chk(port_in[7:4], 4'h5, "input lines follow");
   endtask
   task automatic t_window();
      set_ddr(8'hff);
      acc(16'h0155, 1'b1, 1'b0, 8'hc3, 5);
      acc(16'h0156, 1'b1, 1'b0, 8'h3c, 5);
      acc(16'h0155, 1'b0, 1'b0, 8'h00, 5);
      chk(g_rd, 8'hc3, "ram read back");
      chk(g_ext, 1'b1, "external read flag");
      acc(16'h0181, 1'b1, 1'b0, 8'h96, 5);
      acc(16'h01ff, 1'b0, 1'b0, 8'h00, 5);
      chk(g_rd, 8'h96, "adapter alias");
   endtask
   task automatic t_outside();
      acc(16'h0234, 1'b0, 1'b0, 8'h00, 5);
      chk(g_rd, 8'h34 ^ 8'h5a, "rom read");
      chk(g_ext, 1'b1, "outside read flag");
      INT_RDATA = 8'h3c;
      acc(16'h0080, 1'b0, 1'b1, 8'h00, 0);
      chk(g_rd, 8'h3c, "internal data");
      chk(g_ext, 1'b0, "internal not external");
   endtask
   task automatic toggles(output int t);
      logic prev;
      t = 0;
      prev = p22;
      repeat (600) begin
         @(posedge MCLK);
         #1 t += (p22 !== prev);
         prev = p22;
      end
   endtask
   task automatic t_rate();
      int t0, t1, t2;
      @(posedge MCLK);
      #1 src = CLK_SRC_INT_OUT;
      toggles(t0);
      chk(p22_oe_n, 1'b0, "rate pin driven");
      spd = 2'h1;
      toggles(t1);
      chk(16'(t0 > t1 && t0 > 0), 16'h1, "rate follows speed");
      spd = 2'h2;
      toggles(t2);
      chk(16'(t1 > t2), 16'h1, "rate slows at next speed");
      src = 2'h0;
      repeat (4) @(posedge MCLK);
      #1 chk(p22_oe_n, 1'b1, "rate pin released");
   endtask
   initial begin
      repeat (2) @(posedge MCLK);
      #1 RST = 1'b0;
      t_reset();
      t_blocked();
      t_port_in();
      t_window();
      t_outside();
      t_rate();
      conclude();
   end
   initial begin
      #40000;
      failures++;
      conclude();
   end
endmodule // enb_bus_port_tb_top
